// *** design/smm_map.svh ***
// Register offsets, field positions, record layout and timing for the monitor.
// Assumes a 250 MHz mclk and a 32-bit APB bus with word-aligned registers.
`ifndef SMM_MAP_SVH
`define SMM_MAP_SVH

// Register indices; byte address is four times the index
`define SMM_IDX_CTRL      6'h00
`define SMM_IDX_STAT      6'h01
`define SMM_IDX_ILOG      6'h05
`define SMM_IDX_IBLK      6'h0b
`define SMM_IDX_IDAT      6'h0c
`define SMM_IDX_CNT       6'h0d
`define SMM_IDX_FILT_HI   6'h0e
`define SMM_IDX_FILT_LO   6'h0f
`define SMM_IDX_OWN_RT    6'h10
`define SMM_IDX_LAST_INFO 6'h11

// Control, status and own-address register fields
`define SMM_CTRL_START    15
`define SMM_CTRL_BUFFERED 6
`define SMM_CTRL_ILOG_EN  1
`define SMM_CTRL_STD_A    0
`define SMM_STAT_ACTIVE   3
`define SMM_OWN_RT_EN     5

// Message information word fields
`define SMM_MI_OPCODE     4'h4
`define SMM_MI_RETRY      2'h0
`define SMM_MI_ERR        7
`define SMM_MI_NODATA     6
`define SMM_MI_BCAST      5
`define SMM_MI_TIMEOUT    3
`define SMM_MI_OVERRUN    2
`define SMM_MI_PARITY     1
`define SMM_MI_MANCH      0

// Record layout
`define SMM_REC_WORDS     3'd7
`define SMM_REC_STRIDE    16'h0008
`define SMM_BCAST_RT      5'h1f

// Response time-outs in ns, cycle counts derived from the clock period
`define SMM_CLK_NS        4
`define SMM_RESP_A_NS     9000
`define SMM_RESP_B_NS     15000
`define SMM_RESP_A_CYC    (`SMM_RESP_A_NS / `SMM_CLK_NS)
`define SMM_RESP_B_CYC    (`SMM_RESP_B_NS / `SMM_CLK_NS)

`endif

// *** design/smm_pkg.sv ***
// Types shared by the monitor logger.
// Assumes smm_map.svh supplies all numeric constants.
package smm_pkg;
  typedef enum logic [2:0] {
    SMM_IDLE, SMM_RXD, SMM_STS, SMM_TXD,
    SMM_REC, SMM_DAT, SMM_LOG, SMM_FIN
  } smm_state_t;
endpackage : smm_pkg

// *** design/smm_monitor.sv ***
// Bus monitor logger: follows decoded serial-bus words and writes records
// to external memory over a single-word DMA write port.
// Assumes decoded words and rt_busy come from logic on mclk.
`timescale 1ns/1ps
`include "smm_map.svh"

module smm_monitor
  import smm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wd_valid,
  input  wire logic        wd_cmd_sync,
  input  wire logic        wd_bus_a,
  input  wire logic [15:0] wd_data,
  input  wire logic        wd_par_err,
  input  wire logic        wd_man_err,
  input  wire logic        rt_busy,
  input  wire logic [15:0] time_tag,
  output logic             dma_req,
  output logic      [15:0] dma_addr,
  output logic      [15:0] dma_wdata,
  input  wire logic        dma_ack,
  output logic             msg_logged,
  output logic             count_wrap,
  output logic             monitor_active
);

  // Registers
  logic [15:0] ctrl_reg;
  logic [15:0] ilog_reg;
  logic [15:0] iblk_reg;
  logic [15:0] idat_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_init_reg;
  logic [31:0] filt_reg;
  logic [5:0]  own_reg;
  logic [15:0] last_info_reg;
  logic [15:0] blk_ptr_reg;
  logic [15:0] dat_ptr_reg;
  // Message state
  smm_state_t  state_reg;
  logic [15:0] cmd1_reg;
  logic [15:0] cmd2_reg;
  logic [15:0] st1_reg;
  logic [15:0] st2_reg;
  logic [15:0] tt_reg;
  logic [9:0]  info_reg;
  logic [5:0]  need_reg;
  logic [5:0]  cnt_w_reg;
  logic [5:0]  idx_reg;
  logic        stat_sel_reg;
  logic [11:0] gap_reg;
  logic [15:0] dbuf [0:31];

  // APB decode
  logic [5:0]  widx;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [15:0] rdata16;
  // Word decode
  logic [4:0]  w_rt;
  logic        w_tr;
  logic [4:0]  w_sa;
  logic [4:0]  w_wc;
  logic        w_mode;
  logic        w_nodata;
  logic [5:0]  w_need;
  logic        w_err;
  logic        own_hit;
  logic        std_a;
  logic        buffered;
  logic        timeout;
  logic [15:0] rec_word;
  logic        fin;
  logic        msg_err;

  assign widx     = paddr[7:2];
  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & pready;
  assign std_a    = ctrl_reg[`SMM_CTRL_STD_A];
  assign buffered = ctrl_reg[`SMM_CTRL_BUFFERED];
  assign fin      = (state_reg == SMM_FIN);
  assign msg_err  = info_reg[`SMM_MI_ERR];

  // Command word fields
  assign w_rt     = wd_data[15:11];
  assign w_tr     = wd_data[10];
  assign w_sa     = wd_data[9:5];
  assign w_wc     = wd_data[4:0];
  assign w_mode   = (w_sa == 5'h00) | (~std_a & (w_sa == 5'h1f));
  assign w_nodata = w_mode & (std_a | ~w_wc[4]);
  assign w_need   = w_mode ? {5'h00, ~w_nodata}
                  : ((w_wc == 5'h00) ? 6'h20 : {1'b0, w_wc});
  assign w_err    = wd_par_err | wd_man_err;
  assign own_hit  = own_reg[`SMM_OWN_RT_EN] & (w_rt == own_reg[4:0]);

  // Response gap limit depends on the protocol variant
  assign timeout  = std_a ? (gap_reg >= 12'(`SMM_RESP_A_CYC))
                          : (gap_reg >= 12'(`SMM_RESP_B_CYC));

  // Register read mux
  always_comb begin
    mapped  = 1'b1;
    rdata16 = 16'h0000;
    case (widx)
      `SMM_IDX_CTRL:      rdata16 = ctrl_reg;
      `SMM_IDX_STAT:      rdata16 = {12'h000, monitor_active, 3'h0};
      `SMM_IDX_ILOG:      rdata16 = ilog_reg;
      `SMM_IDX_IBLK:      rdata16 = iblk_reg;
      `SMM_IDX_IDAT:      rdata16 = idat_reg;
      `SMM_IDX_CNT:       rdata16 = cnt_reg;
      `SMM_IDX_FILT_HI:   rdata16 = filt_reg[31:16];
      `SMM_IDX_FILT_LO:   rdata16 = filt_reg[15:0];
      `SMM_IDX_OWN_RT:    rdata16 = {10'h000, own_reg};
      `SMM_IDX_LAST_INFO: rdata16 = last_info_reg;
      default:            mapped  = 1'b0;
    endcase
  end

  // Record word for the current burst slot
  always_comb begin
    case (idx_reg[2:0])
      3'd0:    rec_word = {`SMM_MI_OPCODE, `SMM_MI_RETRY, info_reg};
      3'd1:    rec_word = cmd1_reg;
      3'd2:    rec_word = cmd2_reg;
      3'd3:    rec_word = dat_ptr_reg;
      3'd4:    rec_word = st1_reg;
      3'd5:    rec_word = st2_reg;
      3'd6:    rec_word = tt_reg;
      default: rec_word = 16'h0000;
    endcase
  end

  // APB answer registered in the setup cycle, so pready rises in access
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? {16'h0000, rdata16} : 32'h0000_0000;
    end
  end

  // Host-written configuration
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= 16'h0000;
      iblk_reg     <= 16'h0000;
      idat_reg     <= 16'h0000;
      cnt_init_reg <= 16'h0000;
      filt_reg     <= 32'h0000_0000;
      own_reg      <= 6'h00;
    end else if (wr_en) begin
      case (widx)
        `SMM_IDX_CTRL:    ctrl_reg     <= pwdata[15:0];
        `SMM_IDX_IBLK:    iblk_reg     <= pwdata[15:0];
        `SMM_IDX_IDAT:    idat_reg     <= pwdata[15:0];
        `SMM_IDX_CNT:     cnt_init_reg <= pwdata[15:0];
        `SMM_IDX_FILT_HI: filt_reg[31:16] <= pwdata[15:0];
        `SMM_IDX_FILT_LO: filt_reg[15:0]  <= pwdata[15:0];
        `SMM_IDX_OWN_RT:  own_reg      <= pwdata[5:0];
        default:          ;
      endcase
    end
  end

  // Start bit gates only the start of new messages; pointers taken as loaded by host
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      monitor_active <= 1'b0;
    end else begin
      monitor_active <= ctrl_reg[`SMM_CTRL_START];
    end
  end

  // Block count, pointers and wrap; hardware update wins over host write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg     <= 16'h0000;
      blk_ptr_reg <= 16'h0000;
      dat_ptr_reg <= 16'h0000;
      count_wrap  <= 1'b0;
      msg_logged  <= 1'b0;
    end else begin
      count_wrap <= 1'b0;
      msg_logged <= fin;
      if (fin) begin
        if (cnt_reg == 16'h0001) begin
          // Wrap to the initial pointers and re-arm the count
          cnt_reg     <= cnt_init_reg;
          blk_ptr_reg <= iblk_reg;
          dat_ptr_reg <= idat_reg;
          count_wrap  <= 1'b1;
        end else begin
          cnt_reg     <= cnt_reg - 16'h0001;
          blk_ptr_reg <= blk_ptr_reg + `SMM_REC_STRIDE;
          if (!msg_err) begin
            dat_ptr_reg <= dat_ptr_reg + {10'h000, cnt_w_reg};
          end
        end
      end else if (wr_en && widx == `SMM_IDX_CNT) begin
        cnt_reg <= pwdata[15:0];
      end else if (!monitor_active) begin
        // Idle monitor tracks the initial pointers
        blk_ptr_reg <= iblk_reg;
        dat_ptr_reg <= idat_reg;
      end
    end
  end

  // Interrupt log pointer; hardware owns the low five bits as a ring
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ilog_reg <= 16'h0000;
    end else if (state_reg == SMM_LOG && dma_ack) begin
      ilog_reg <= {ilog_reg[15:5], ilog_reg[4:0] + 5'h01};
    end else if (wr_en && widx == `SMM_IDX_ILOG) begin
      ilog_reg <= pwdata[15:0];
    end
  end

  // Silence timer between words
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 12'h000;
    end else if (wd_valid || state_reg == SMM_IDLE) begin
      gap_reg <= 12'h000;
    end else if (!timeout) begin
      gap_reg <= gap_reg + 12'h001;
    end
  end

  // Buffered data words; kept until post-processing
  always_ff @(posedge mclk) begin
    if (wd_valid && !wd_cmd_sync &&
        (state_reg == SMM_RXD || state_reg == SMM_TXD)) begin
      dbuf[cnt_w_reg[4:0]] <= wd_data;
    end
  end

  // Message sequencer and DMA write issue
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= SMM_IDLE;
      cmd1_reg      <= 16'h0000;
      cmd2_reg      <= 16'h0000;
      st1_reg       <= 16'h0000;
      st2_reg       <= 16'h0000;
      tt_reg        <= 16'h0000;
      info_reg      <= 10'h000;
      need_reg      <= 6'h00;
      cnt_w_reg     <= 6'h00;
      idx_reg       <= 6'h00;
      stat_sel_reg  <= 1'b0;
      last_info_reg <= 16'h0000;
      dma_req       <= 1'b0;
      dma_addr      <= 16'h0000;
      dma_wdata     <= 16'h0000;
    end else begin
      if (dma_ack) begin
        dma_req <= 1'b0;
      end
      case (state_reg)
        SMM_IDLE: begin
          // Skip own address, busy terminal and unfiltered addresses
          if (wd_valid && wd_cmd_sync && monitor_active && !rt_busy &&
              !w_err && !own_hit && filt_reg[w_rt]) begin
            cmd1_reg     <= wd_data;
            cmd2_reg     <= 16'h0000;
            st1_reg      <= 16'h0000;
            st2_reg      <= 16'h0000;
            tt_reg       <= time_tag;
            info_reg     <= {wd_bus_a, 1'b0, 1'b0, w_nodata,
                             w_rt == `SMM_BCAST_RT, 5'h00};
            need_reg     <= w_need;
            cnt_w_reg    <= 6'h00;
            stat_sel_reg <= 1'b0;
            if (w_tr || w_need == 6'h00) begin
              state_reg <= SMM_STS;
            end else begin
              state_reg <= SMM_RXD;
            end
            if (w_rt == `SMM_BCAST_RT) begin
              info_reg[`SMM_MI_BCAST] <= 1'b1;
            end
          end
        end
        SMM_RXD, SMM_TXD: begin
          if (rt_busy) begin
            state_reg <= SMM_IDLE;
          end else if (wd_valid && wd_cmd_sync && own_hit) begin
            state_reg <= SMM_IDLE;
          end else if (wd_valid && wd_cmd_sync && state_reg == SMM_RXD &&
                       cnt_w_reg == 6'h00 && w_tr && !info_reg[8]) begin
            // Transmit command right after receive: terminal to terminal
            cmd2_reg    <= wd_data;
            info_reg[8] <= 1'b1;
            need_reg    <= w_need;
            state_reg   <= SMM_STS;
            if (w_err) begin
              info_reg[`SMM_MI_ERR] <= 1'b1;
            end
          end else if (wd_valid && wd_cmd_sync) begin
            // Status where data was due: short message, status still kept
            if (!stat_sel_reg) begin
              st1_reg <= wd_data;
            end else begin
              st2_reg <= wd_data;
            end
            info_reg[`SMM_MI_TIMEOUT] <= 1'b1;
            info_reg[`SMM_MI_ERR]     <= 1'b1;
            state_reg <= SMM_REC;
            idx_reg   <= 6'h00;
          end else if (wd_valid) begin
            cnt_w_reg <= cnt_w_reg + 6'h01;
            if (wd_par_err) begin
              info_reg[`SMM_MI_PARITY] <= 1'b1;
              info_reg[`SMM_MI_ERR]    <= 1'b1;
            end
            if (wd_man_err) begin
              info_reg[`SMM_MI_MANCH] <= 1'b1;
              info_reg[`SMM_MI_ERR]   <= 1'b1;
            end
            if (!buffered) begin
              dma_req   <= 1'b1;
              dma_addr  <= dat_ptr_reg + {10'h000, cnt_w_reg};
              dma_wdata <= wd_data;
            end
            if (cnt_w_reg + 6'h01 == need_reg) begin
              if (state_reg == SMM_RXD && !info_reg[`SMM_MI_BCAST]) begin
                state_reg <= SMM_STS;
              end else if (state_reg == SMM_TXD && info_reg[8]) begin
                state_reg <= SMM_STS;
              end else begin
                state_reg <= SMM_REC;
                idx_reg   <= 6'h00;
              end
            end
          end else if (timeout) begin
            info_reg[`SMM_MI_TIMEOUT] <= 1'b1;
            info_reg[`SMM_MI_ERR]     <= 1'b1;
            state_reg <= SMM_REC;
            idx_reg   <= 6'h00;
          end
        end
        SMM_STS: begin
          if (rt_busy) begin
            state_reg <= SMM_IDLE;
          end else if (wd_valid && wd_cmd_sync) begin
            // One information set for the whole message
            if (!stat_sel_reg) begin
              st1_reg <= wd_data;
            end else begin
              st2_reg <= wd_data;
            end
            stat_sel_reg <= 1'b1;
            if (wd_par_err) begin
              info_reg[`SMM_MI_PARITY] <= 1'b1;
              info_reg[`SMM_MI_ERR]    <= 1'b1;
            end
            if (wd_man_err) begin
              info_reg[`SMM_MI_MANCH] <= 1'b1;
              info_reg[`SMM_MI_ERR]   <= 1'b1;
            end
            if (!stat_sel_reg && (cmd1_reg[10] || info_reg[8]) &&
                need_reg != 6'h00) begin
              cnt_w_reg <= 6'h00;
              state_reg <= SMM_TXD;
            end else begin
              state_reg <= SMM_REC;
              idx_reg   <= 6'h00;
            end
          end else if (wd_valid) begin
            // Data word where only a status was expected
            info_reg[`SMM_MI_OVERRUN] <= 1'b1;
            info_reg[`SMM_MI_ERR]     <= 1'b1;
            state_reg <= SMM_REC;
            idx_reg   <= 6'h00;
          end else if (timeout) begin
            info_reg[`SMM_MI_ERR] <= 1'b1;
            state_reg <= SMM_REC;
            idx_reg   <= 6'h00;
          end
        end
        SMM_REC: begin
          // Seven-word burst; the eighth slot is never written
          if (!dma_req) begin
            if (idx_reg[2:0] == `SMM_REC_WORDS) begin
              idx_reg   <= 6'h00;
              state_reg <= (buffered && !msg_err && cnt_w_reg != 6'h00)
                           ? SMM_DAT : SMM_LOG;
            end else begin
              dma_req   <= 1'b1;
              dma_addr  <= blk_ptr_reg + {13'h0000, idx_reg[2:0]};
              dma_wdata <= rec_word;
              idx_reg   <= idx_reg + 6'h01;
            end
          end
        end
        SMM_DAT: begin
          if (!dma_req) begin
            if (idx_reg == cnt_w_reg) begin
              idx_reg   <= 6'h00;                                  // Log entry keys on zero
              state_reg <= SMM_LOG;
            end else begin
              dma_req   <= 1'b1;
              dma_addr  <= dat_ptr_reg + {10'h000, idx_reg};
              dma_wdata <= dbuf[idx_reg[4:0]];
              idx_reg   <= idx_reg + 6'h01;
            end
          end
        end
        SMM_LOG: begin
          // Optional log entry holds the record address
          if (!ctrl_reg[`SMM_CTRL_ILOG_EN]) begin
            state_reg <= SMM_FIN;
          end else if (dma_req && dma_ack) begin
            state_reg <= SMM_FIN;
          end else if (!dma_req && idx_reg == 6'h00) begin
            dma_req   <= 1'b1;
            dma_addr  <= ilog_reg;
            dma_wdata <= blk_ptr_reg;
            idx_reg   <= 6'h01;
          end
        end
        SMM_FIN: begin
          last_info_reg <= {`SMM_MI_OPCODE, `SMM_MI_RETRY, info_reg};
          state_reg     <= SMM_IDLE;
        end
        default: state_reg <= SMM_IDLE;
      endcase
    end
  end

endmodule : smm_monitor

// *** tb/smm_sva.sv ***
// Checker for the monitor's register bus and DMA port timing.
// Assumes a single mclk domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module smm_sva (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dma_req,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  input wire logic        dma_ack,
  input wire logic        msg_logged,
  input wire logic        count_wrap
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // DMA write must stand unchanged until memory answers
  a_req_holds: assert property (
    dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_wdata))
    else $error("dma request changed before ack");
  a_ack_drops: assert property (dma_ack |=> !dma_req)
    else $error("dma request held after ack");
  // Zero wait states: answer exactly one cycle after setup
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_only: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slave error outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_log_pulse: assert property (msg_logged |=> !msg_logged)
    else $error("logged flag longer than a cycle");
  a_wrap_pulse: assert property (count_wrap |=> !count_wrap)
    else $error("wrap flag longer than a cycle");
  c_wrap: cover property (count_wrap);
  c_err: cover property (pslverr);
  c_log: cover property (msg_logged ##1 !msg_logged);
endmodule : smm_sva

// *** tb/smm_mem_model.sv ***
// Memory-side partner of the monitor's single-word DMA write port.
// Assumes requests stand until ack; answers after zero to three idle cycles.
`timescale 1ns/1ps
module smm_mem_model (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic dma_req,
  output logic      dma_ack
);
  logic [15:0] lfsr_reg;
  logic [1:0]  wait_reg;
  // Varying delay so both prompt and slow answers are seen
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma_ack  <= 1'h0;
      wait_reg <= 2'h0;
      lfsr_reg <= 16'hace1;
    end else if (dma_ack) begin
      dma_ack  <= 1'h0; // One pulse; never ack the dropping request
      wait_reg <= lfsr_reg[1:0];
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end else if (dma_req) begin
      if (wait_reg == 2'h0) dma_ack <= 1'h1;
      else wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule : smm_mem_model

// *** tb/smm_monitor_bench.sv ***
// Self-checking bench: sets up over APB, feeds decoded bus words, checks DMA records.
// Assumes smm_map.svh indices and a memory model answering the DMA port.
`timescale 1ns/1ps
`include "smm_map.svh"
module smm_monitor_bench;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, er, rt_busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        wd_valid, wd_cmd_sync, wd_bus_a, wd_par_err, wd_man_err;
  logic [15:0] wd_data, time_tag, dma_addr, dma_wdata, tt, d0;
  logic        dma_req, dma_ack, msg_logged, count_wrap, monitor_active;
  logic [32:0] exp_q [$];
  logic [32:0] ex;
  int          n_fail, samples_checked, n_log, n_wrap;
  smm_monitor i_smm_monitor (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wd_valid, .wd_cmd_sync, .wd_bus_a, .wd_data, .wd_par_err,
    .wd_man_err, .rt_busy, .time_tag, .dma_req, .dma_addr, .dma_wdata, .dma_ack,
    .msg_logged, .count_wrap, .monitor_active);
  smm_mem_model i_smm_mem_model (.mclk, .resetn, .dma_req, .dma_ack);
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int k;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, idx, 2'h0, d};
    @(posedge mclk);
    penable <= 1'h1;
    for (k = 0; k < 20 && pready !== 1'h1; k++) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (k == 20) begin
      n_fail++;
      results();
    end
  endtask : apb
  // One decoded word, then a quiet gap
  task automatic wd(input logic [15:0] d, input logic c, input logic a, input logic [1:0] e);
    @(posedge mclk);
    {wd_valid, wd_cmd_sync, wd_bus_a, wd_man_err, wd_par_err, wd_data} <= {1'h1, c, a, e, d};
    @(posedge mclk);
    wd_valid <= 1'h0;
    repeat (10) @(posedge mclk);
  endtask : wd
  // Notes are {free, address, data} in DMA order; free marks contents not checked
  task automatic rec(input logic [15:0] b, mi, c1, c2, dp, s1, s2, input logic [2:0] dc);
    exp_q.push_back({1'h0, b, mi});
    exp_q.push_back({1'h0, b + 16'h1, c1});
    exp_q.push_back({dc[2], b + 16'h2, c2});
    exp_q.push_back({1'h0, b + 16'h3, dp});
    exp_q.push_back({dc[1], b + 16'h4, s1});
    exp_q.push_back({dc[0], b + 16'h5, s2});
    exp_q.push_back({1'h0, b + 16'h6, tt});
  endtask : rec
  task automatic wait_log(input int want, input string nm);
    int k;
    for (k = 0; k < 3000 && n_log < want; k++) @(posedge mclk);
    repeat (20) @(posedge mclk);
    chk({nm, " logged"}, want, n_log);
    chk({nm, " pending"}, 0, exp_q.size());
    $display("test %s done", nm);
    if (k == 3000) begin
      n_fail++;
      results();
    end
  endtask : wait_log
  task automatic one(input string nm, input logic [15:0] c, input int nd, input logic a,
                     input logic [1:0] e, input logic [15:0] mi, b, dp, input int n);
    logic bc;
    int   i;
    bc = (c[15:11] == 5'h1f);
    tt = xs();
    time_tag <= tt;
    rec(b, mi, c, 16'h0, dp, {c[15:11], 11'h0}, 16'h0, {1'h1, bc, 1'h1});
    wd(c, 1'h1, a, 2'h0);
    for (i = 0; i < nd; i++) begin
      d0 = xs();
      if (!mi[7]) exp_q.push_back({1'h0, dp + 16'(i), d0});
      wd(d0, 1'h0, a, 2'h0);
    end
    if (!bc) wd({c[15:11], 11'h0}, 1'h1, a, e);
    wait_log(n, nm);
  endtask : one
  task automatic quiet(input logic [15:0] c);
    wd(c, 1'h1, 1'h1, 2'h0);
    wd(xs(), 1'h0, 1'h1, 2'h0);
    wd({c[15:11], 11'h0}, 1'h1, 1'h1, 2'h0);
  endtask : quiet
  // Each DMA write takes the oldest note; a write with no note is a mismatch
  always @(posedge mclk) begin
    if (resetn && dma_req && dma_ack) begin
      if (exp_q.size() == 0) chk("dma stray", 32'h0, {16'hffff, dma_addr});
      else begin
        ex = exp_q.pop_front();
        chk("dma addr", {16'h0, ex[31:16]}, {16'h0, dma_addr});
        if (!ex[32]) chk("dma word", {16'h0, ex[15:0]}, {16'h0, dma_wdata});
      end
    end
    if (resetn && msg_logged === 1'h1) n_log++;
    if (resetn && count_wrap === 1'h1) n_wrap++;
  end
  initial begin
    seed = 32'h0001_6343;
    {psel, penable, pwrite, paddr, pwdata, rt_busy, time_tag} = '0;
    {wd_valid, wd_cmd_sync, wd_bus_a, wd_par_err, wd_man_err, wd_data} = '0;
    {n_fail, samples_checked, n_log, n_wrap} = '0;
    resetn = 1'h0;
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    apb(1'h0, `SMM_IDX_FILT_LO, 32'h0);
    chk("filter reset", 32'h0, rd);
    apb(1'h0, 6'h3f, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'h1, `SMM_IDX_IBLK, 32'h0100);
    apb(1'h1, `SMM_IDX_IDAT, 32'h0200);
    apb(1'h1, `SMM_IDX_CNT, 32'h0002);
    apb(1'h1, `SMM_IDX_FILT_LO, 32'h0020);
    apb(1'h1, `SMM_IDX_FILT_HI, 32'h8000);
    apb(1'h1, `SMM_IDX_OWN_RT, 32'h0021);
    apb(1'h0, `SMM_IDX_FILT_HI, 32'h0);
    chk("filter readback", 32'h8000, rd);
    quiet(16'h2821);
    wait_log(0, "before start");
    apb(1'h1, `SMM_IDX_CTRL, 32'h8040);
    repeat (2) @(posedge mclk);
    chk("active", 32'h1, {31'h0, monitor_active});
    quiet(16'h0821);
    quiet(16'h3021);
    wait_log(0, "own and unfiltered");
    one("receive", 16'h2822, 2, 1'h1, 2'h0, 16'h4200, 16'h0100, 16'h0200, 1);
    one("parity", 16'h2821, 1, 1'h0, 2'h1, 16'h4082, 16'h0108, 16'h0202, 2);
    chk("first wrap", 32'h1, n_wrap);
    one("manchester", 16'h2821, 1, 1'h1, 2'h2, 16'h4281, 16'h0100, 16'h0200, 3);
    // Terminal to terminal: receive command, transmit command, two statuses
    tt = xs();
    time_tag <= tt;
    d0 = xs();
    rec(16'h0108, 16'h4300, 16'h2821, 16'h3c21, 16'h0200, 16'h3800, 16'h2800, 3'h0);
    exp_q.push_back({1'h0, 16'h0200, d0});
    wd(16'h2821, 1'h1, 1'h1, 2'h0);
    wd(16'h3c21, 1'h1, 1'h1, 2'h0);
    wd(16'h3800, 1'h1, 1'h1, 2'h0);
    wd(d0, 1'h0, 1'h1, 2'h0);
    wd(16'h2800, 1'h1, 1'h1, 2'h0);
    wait_log(4, "rt to rt");
    one("mode code", 16'h2c02, 0, 1'h1, 2'h0, 16'h4240, 16'h0100, 16'h0200, 5);
    one("short data", 16'h2822, 1, 1'h1, 2'h0, 16'h4288, 16'h0108, 16'h0200, 6);
    chk("third wrap", 32'h3, n_wrap);
    one("broadcast", 16'hf821, 1, 1'h1, 2'h0, 16'h4220, 16'h0100, 16'h0200, 7);
    // Terminal busy: the started message is dropped, later words ignored
    wd(16'h2821, 1'h1, 1'h1, 2'h0);
    rt_busy <= 1'h1;
    quiet(16'h2821);
    rt_busy <= 1'h0;
    wait_log(7, "preempted");
    // Unbuffered with log entry: data leaves during reception, before the record
    apb(1'h1, `SMM_IDX_ILOG, 32'h0400);
    apb(1'h1, `SMM_IDX_CTRL, 32'h8002);
    tt = xs();
    time_tag <= tt;
    d0 = xs();
    exp_q.push_back({1'h0, 16'h0201, d0});
    rec(16'h0108, 16'h4200, 16'h2821, 16'h0, 16'h0201, 16'h2800, 16'h0, 3'h5);
    exp_q.push_back({1'h0, 16'h0400, 16'h0108});
    wd(16'h2821, 1'h1, 1'h1, 2'h0);
    wd(d0, 1'h0, 1'h1, 2'h0);
    wd(16'h2800, 1'h1, 1'h1, 2'h0);
    wait_log(8, "unbuffered");
    chk("fourth wrap", 32'h4, n_wrap);
    results();
  end
endmodule : smm_monitor_bench
bind smm_monitor smm_sva i_smm_sva (.mclk, .resetn, .psel, .penable, .prdata, .pready,
  .pslverr, .dma_req, .dma_addr, .dma_wdata, .dma_ack, .msg_logged, .count_wrap);
